/* rtl/indirect_parameter_access_regs.sv */
// Register bank with commanded/current operation mode and an indirect parameter window.
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_params.svh"

module indirect_parameter_access_regs #(
   parameter int DATA_W = 16
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Network register port, one access per strobe.
   input wire logic i_net_wr,
   input wire logic i_net_rd,
   input wire logic [15:0] i_net_reg,
   input wire logic [DATA_W-1:0] i_net_wdata,
   output logic o_net_ack,
   output logic o_net_err,
   output logic [DATA_W-1:0] o_net_rdata,
   // Operation mode link to the drive.
   output logic o_mode_req,
   output logic [DATA_W-1:0] o_mode_value,
   input wire logic [DATA_W-1:0] i_drive_mode,
   // Drive parameter transaction engine.
   output logic o_drv_req,
   output logic o_drv_write,
   output logic [DATA_W-1:0] o_drv_addr,
   output logic [DATA_W-1:0] o_drv_wdata,
   input wire logic i_drv_done,
   input wire logic [7:0] i_drv_code,
   input wire logic [DATA_W-1:0] i_drv_rdata
);

   // ==========================================================
   // Elaboration check.
   // The status word packs two status bytes and the register numbers are
   // fixed at 16 bits, so no other data width can be served.
   if (DATA_W != 16)
   begin : g_width_check
      $error("DATA_W must be 16: the status word is two bytes.");
   end

   // Reset pattern of the status word, split into its two bytes below.
   localparam logic [15:0] STATUS_IDLE = `RESET_STATUS;

   // ==========================================================
   // State.
   // Every register of the bank lives here; the next values are formed in the
   // single combinational process below and only registered in the clocked one.
   logic [DATA_W-1:0] cmd_mode_q, cmd_mode_d;    // Last network-written mode.
   logic [DATA_W-1:0] cur_mode_q, cur_mode_d;    // Drive's reported mode.
   logic [DATA_W-1:0] addr_q, addr_d;            // Indirect target number.
   logic [DATA_W-1:0] value_q, value_d;          // Indirect value.
   logic [7:0] rd_code_q, rd_code_d;             // Read status byte.
   logic [7:0] wr_code_q, wr_code_d;             // Write status byte.
   logic wr_pend_q, wr_pend_d;                   // Value write awaiting issue.
   logic [DATA_W-1:0] wr_data_q, wr_data_d;      // Data of the pending write.
   logic stale_q, stale_d;                       // Answer in flight is for an old address.
   indirect_access_pkg::engine_state_e st_q, st_d;
   logic ack_q, ack_d;
   logic err_q, err_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic mode_req_q, mode_req_d;
   logic drv_req_q, drv_req_d;
   logic drv_write_q, drv_write_d;
   logic [DATA_W-1:0] drv_addr_q, drv_addr_d;
   logic [DATA_W-1:0] drv_wdata_q, drv_wdata_d;

   // Decoded network accesses.
   // Writes to the read-only status and current-mode numbers decode to nothing,
   // so they are acknowledged without side effects.
   logic wr_addr;
   logic wr_value;
   logic in_mirror;

   assign wr_addr = i_net_wr && (i_net_reg == `REG_TARGET_ADDRESS);
   assign wr_value = i_net_wr && (i_net_reg == `REG_TARGET_VALUE);
   assign in_mirror = (i_net_reg >= `REG_MIRROR_FIRST) && (i_net_reg <= `REG_MIRROR_LAST);

   // ==========================================================
   // Next-state logic for registers, status and the drive engine.
   // Only one drive transaction is in flight; an answer that returns after the
   // address moved is discarded so a stale value never reaches the window.
   // The price is one idle cycle between drive transactions, which keeps the
   // engine free of any queue beyond the single pending value write.
   always_comb
   begin
      cmd_mode_d = cmd_mode_q;
      cur_mode_d = i_drive_mode;
      addr_d = addr_q;
      value_d = value_q;
      rd_code_d = rd_code_q;
      wr_code_d = wr_code_q;
      wr_pend_d = wr_pend_q;
      wr_data_d = wr_data_q;
      stale_d = stale_q;
      st_d = st_q;
      ack_d = i_net_wr || i_net_rd;
      err_d = (i_net_wr || i_net_rd) && !in_mirror && (i_net_reg != `REG_CURRENT_MODE);
      rdata_d = rdata_q;
      mode_req_d = 1'b0;
      // The mode output is the commanded register itself and needs no default.
      drv_req_d = 1'b0;
      drv_write_d = drv_write_q;
      drv_addr_d = drv_addr_q;
      drv_wdata_d = drv_wdata_q;

      // Network reads: mirrored registers always answer.
      if (i_net_rd)
      begin
         case (i_net_reg)
            `REG_COMMANDED_MODE: rdata_d = cmd_mode_q;
            `REG_TARGET_ADDRESS: rdata_d = addr_q;
            `REG_TARGET_VALUE: rdata_d = value_q;
            `REG_ACCESS_STATUS: rdata_d = {wr_code_q, rd_code_q};
            `REG_CURRENT_MODE: rdata_d = cur_mode_q;
            default: rdata_d = `RESET_WORD;
         endcase
      end

      // Drive engine answers.
      case (st_q)
         // A read answer updates the read byte; a failed read leaves the last
         // good value in place, which the not-ready or error code qualifies.
         indirect_access_pkg::ST_READ:
         begin
            if (i_drv_done)
            begin
               st_d = indirect_access_pkg::ST_IDLE;
               if (!stale_q && addr_q != `RESET_WORD)
               begin
                  rd_code_d = i_drv_code;
                  if (i_drv_code == `CODE_SUCCESS)
                  begin
                     value_d = i_drv_rdata;
                  end
               end
            end
         end
         // A write answer only ever touches the write byte; there is no retry,
         // so a failed code stands until the client acts again.
         indirect_access_pkg::ST_WRITE:
         begin
            if (i_drv_done)
            begin
               st_d = indirect_access_pkg::ST_IDLE;
               if (!stale_q)
               begin
                  wr_code_d = i_drv_code;
               end
            end
         end
         indirect_access_pkg::ST_IDLE:
         begin
            // A queued write goes first, then re-reading resumes.
            if (wr_pend_q && addr_q != `RESET_WORD)
            begin
               st_d = indirect_access_pkg::ST_WRITE;
               drv_req_d = 1'b1;
               drv_write_d = 1'b1;
               drv_addr_d = addr_q;
               drv_wdata_d = wr_data_q;
               wr_pend_d = 1'b0;
               stale_d = 1'b0;
            end
            else if (addr_q != `RESET_WORD)
            begin
               st_d = indirect_access_pkg::ST_READ;
               drv_req_d = 1'b1;
               drv_write_d = 1'b0;
               drv_addr_d = addr_q;
               stale_d = 1'b0;
            end
         end
         default: st_d = indirect_access_pkg::ST_IDLE;
      endcase

      // Network writes override engine updates in the same cycle.
      // They come last so that a client action always wins over an answer that
      // lands in the same cycle, as the client cannot see that answer anyway.
      if (i_net_wr && i_net_reg == `REG_COMMANDED_MODE)
      begin
         cmd_mode_d = i_net_wdata;
         mode_req_d = 1'b1;
      end
      if (wr_value && addr_q != `RESET_WORD)
      begin
         value_d = i_net_wdata;
         wr_data_d = i_net_wdata;
         wr_pend_d = 1'b1;
         wr_code_d = `CODE_NOT_READY;
      end
      if (wr_addr)
      begin
         addr_d = i_net_wdata;
         value_d = `RESET_WORD;
         rd_code_d = `CODE_NOT_READY;
         wr_pend_d = 1'b0;
         if (i_net_wdata != addr_q)
         begin
            wr_code_d = `CODE_NOT_READY;
         end
         // Any transaction still outstanding after this edge, including one
         // issued in this very cycle for the old number, must be discarded.
         if (st_d != indirect_access_pkg::ST_IDLE)
         begin
            stale_d = 1'b1;
         end
      end

      // Disabled window holds zero value and the idle status pattern: read byte not-ready, write byte zero.
      // It is applied to the next address, so the write of zero takes effect at once.
      if (addr_d == `RESET_WORD)
      begin
         value_d = `RESET_WORD;
         rd_code_d = STATUS_IDLE[7:0];
         wr_code_d = STATUS_IDLE[15:8];
         wr_pend_d = 1'b0;
      end
   end

   // ==========================================================
   // Register stage; everything resets to the disabled window.
   // Reset is synchronous, so a request pulse in flight at reset is simply
   // lost; the drive side must not hold an answer across a reset.
   always_ff @(posedge i_core_clk)
   begin
      if (!i_reset_n)
      begin
         cmd_mode_q <= `RESET_WORD;
         cur_mode_q <= `RESET_WORD;
         addr_q <= `RESET_WORD;
         value_q <= `RESET_WORD;
         rd_code_q <= STATUS_IDLE[7:0];
         wr_code_q <= STATUS_IDLE[15:8];
         wr_pend_q <= 1'b0;
         wr_data_q <= `RESET_WORD;
         stale_q <= 1'b0;
         st_q <= indirect_access_pkg::ST_IDLE;
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= `RESET_WORD;
         mode_req_q <= 1'b0;
         drv_req_q <= 1'b0;
         drv_write_q <= 1'b0;
         drv_addr_q <= `RESET_WORD;
         drv_wdata_q <= `RESET_WORD;
      end
      else
      begin
         cmd_mode_q <= cmd_mode_d;
         cur_mode_q <= cur_mode_d;
         addr_q <= addr_d;
         value_q <= value_d;
         rd_code_q <= rd_code_d;
         wr_code_q <= wr_code_d;
         wr_pend_q <= wr_pend_d;
         wr_data_q <= wr_data_d;
         stale_q <= stale_d;
         st_q <= st_d;
         ack_q <= ack_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
         mode_req_q <= mode_req_d;
         drv_req_q <= drv_req_d;
         drv_write_q <= drv_write_d;
         drv_addr_q <= drv_addr_d;
         drv_wdata_q <= drv_wdata_d;
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops.
   // The mode value is the commanded register itself, not a copy, so the value
   // read back at the commanded-mode number and the value offered never differ.
   assign o_net_ack = ack_q;
   assign o_net_err = err_q;
   assign o_net_rdata = rdata_q;
   assign o_mode_req = mode_req_q;
   assign o_mode_value = cmd_mode_q;
   assign o_drv_req = drv_req_q;
   assign o_drv_write = drv_write_q;
   assign o_drv_addr = drv_addr_q;
   assign o_drv_wdata = drv_wdata_q;

endmodule : indirect_parameter_access_regs
`default_nettype wire

/* inc/indirect_access_params.svh */
// Register offsets, status codes and reset values of the indirect parameter access bank.
`ifndef INDIRECT_ACCESS_PARAMS_SVH
`define INDIRECT_ACCESS_PARAMS_SVH

// ==========================================================
// Register numbers as seen by the network client.
`define REG_COMMANDED_MODE 16'h000a
`define REG_TARGET_ADDRESS 16'h0064
`define REG_TARGET_VALUE 16'h0065
`define REG_ACCESS_STATUS 16'h0066
`define REG_CURRENT_MODE 16'h0106
`define REG_MIRROR_FIRST 16'h0002
`define REG_MIRROR_LAST 16'h01fc

// ==========================================================
// Status byte codes.
`define CODE_SUCCESS 8'h00
`define CODE_BAD_PARAM 8'h02
`define CODE_BAD_DATA 8'h03
`define CODE_LINK_LOST 8'h07
`define CODE_OTHER 8'h0a
`define CODE_NOT_READY 8'hff

// ==========================================================
// Field positions and reset values.
`define STATUS_READ_LSB 0
`define STATUS_WRITE_LSB 8
`define RESET_WORD 16'h0000
`define RESET_STATUS 16'h00ff

`endif

/* inc/indirect_access_pkg.sv */
// Types shared by the indirect parameter access bank.
`default_nettype none
package indirect_access_pkg;

   // Drive-side transaction engine states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE
   } engine_state_e;

endpackage : indirect_access_pkg
`default_nettype wire

/* verification/indirect_parameter_access_regs_properties.sv */
// Port relations of the indirect parameter access bank.
`timescale 1ns/1ps
`default_nettype none
// =====
// Checker watching the network side and the drive request strobe.
module indirect_access_checker #(
   parameter int DATA_W = 16
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Network port.
   input wire logic i_net_wr,
   input wire logic i_net_rd,
   input wire logic [15:0] i_net_reg,
   input wire logic [DATA_W-1:0] i_net_wdata,
   input wire logic o_net_ack,
   input wire logic o_net_err,
   input wire logic [DATA_W-1:0] o_net_rdata,
   // Mode link and drive engine.
   input wire logic o_mode_req,
   input wire logic [DATA_W-1:0] o_mode_value,
   input wire logic o_drv_req
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic tk = i_net_wr | i_net_rd;
   property p_ack; tk |=> o_net_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_ok; tk && i_net_reg >= 16'h0002 && i_net_reg <= 16'h01fc |=> !o_net_err; endproperty
   a_ok: assert property (p_ok) else $error("mirrored access refused");
   property p_err; tk && i_net_reg > 16'h01fc && i_net_reg != 16'h0106 |=> o_net_err; endproperty
   a_err: assert property (p_err) else $error("unmapped access accepted");
   property p_mode; i_net_wr && i_net_reg == 16'h000a |=> o_mode_req && o_mode_value == $past(i_net_wdata); endproperty
   a_mode: assert property (p_mode) else $error("mode not forwarded");
   property p_hold; !(i_net_wr && i_net_reg == 16'h000a) |=> $stable(o_mode_value); endproperty
   a_hold: assert property (p_hold) else $error("mode changed");
   property p_one; o_drv_req |=> !o_drv_req; endproperty
   a_one: assert property (p_one) else $error("request too long");
   // Two cycles after the address write no drive answer can have landed yet.
   property p_nrdy; i_net_wr && i_net_reg == 16'h0064 && i_net_wdata != 16'h0000 ##2 i_net_rd && i_net_reg == 16'h0066 |=> o_net_rdata == 16'hffff; endproperty
   a_nrdy: assert property (p_nrdy) else $error("status not pending");
   property p_zero; i_net_wr && i_net_reg == 16'h0064 && i_net_wdata == 16'h0000 ##2 i_net_rd && i_net_reg == 16'h0066 |=> o_net_rdata == 16'h00ff; endproperty
   a_zero: assert property (p_zero) else $error("disabled status wrong");
endmodule : indirect_access_checker
bind indirect_parameter_access_regs indirect_access_checker #(.DATA_W(DATA_W)) u_chk (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_net_wr(i_net_wr), .i_net_rd(i_net_rd),
   .i_net_reg(i_net_reg), .i_net_wdata(i_net_wdata), .o_net_ack(o_net_ack),
   .o_net_err(o_net_err), .o_net_rdata(o_net_rdata), .o_mode_req(o_mode_req),
   .o_mode_value(o_mode_value), .o_drv_req(o_drv_req));
`default_nettype wire

/* verification/drive_model.sv */
// Behavioural drive parameter engine answering the bank's requests.
`timescale 1ns/1ps
`default_nettype none
// =====
module drive_model (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // Request from the bank and answer settings from the bench.
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   input wire logic [3:0] i_lat,
   input wire logic [7:0] i_code,
   // Answer.
   output logic o_done,
   output logic [7:0] o_code,
   output logic [15:0] o_rdata
);
   logic [3:0] cnt_q;
   // Answers i_lat cycles after a request; between answers the lines toggle so stale data shows.
   always_ff @(posedge i_core_clk)
   begin
      o_done <= 1'b0;
      o_code <= ~o_code;
      o_rdata <= ~o_rdata;
      if (i_req)
         cnt_q <= i_lat;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1)
      begin
         o_done <= 1'b1;
         o_code <= i_code;
         o_rdata <= i_addr ^ 16'h00ff;
      end
      if (!i_reset_n)
      begin
         cnt_q <= 4'h0;
         o_code <= 8'h00;
         o_rdata <= 16'h0000;
      end
   end
endmodule : drive_model
`default_nettype wire

/* verification/indirect_parameter_access_regs_tb.sv */
// Self-checking bench for the indirect parameter access bank.
`timescale 1ns/1ps
`default_nettype none
// =====
module indirect_parameter_access_regs_tb;
   logic clk, rst_n, wr, rd, done, req, ack, err, mreq;
   logic [15:0] reg_n, wd, rdat, dmode, daddr, drd, rv, mval;
   logic [7:0] code, dcode;
   logic [3:0] lat;
   logic dwr;
   logic [15:0] dwd, wlast;
   logic [7:0] rd_errs [3] = '{8'h02, 8'h07, 8'h0a};
   int n_fail, comparisons, cyc;
   indirect_parameter_access_regs uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_net_wr(wr),
      .i_net_rd(rd), .i_net_reg(reg_n), .i_net_wdata(wd), .o_net_ack(ack), .o_net_err(err),
      .o_net_rdata(rdat), .o_mode_req(mreq), .o_mode_value(mval), .i_drive_mode(dmode),
      .o_drv_req(req), .o_drv_write(dwr), .o_drv_addr(daddr), .o_drv_wdata(dwd), .i_drv_done(done),
      .i_drv_code(dcode), .i_drv_rdata(drd));
   drive_model u_drv (.i_core_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_addr(daddr),
      .i_lat(lat), .i_code(code), .o_done(done), .o_code(dcode), .o_rdata(drd));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Last write data handed to the drive, judged after each of the two value writes of t_write.
   always @(posedge clk)
   begin
      if (req && dwr)
         wlast <= dwd;
   end
   // A hang counts as a mismatch.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         results();
      end
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // One strobe, then the ack edge; ack and err are judged there.
   task net(input logic w, input logic [15:0] r, input logic [15:0] d, input logic e);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      reg_n <= r;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 rv = rdat;
      chk({14'h0, ack, err}, {14'h0, 1'b1, e});
   endtask : net
   task poll(input int sh, input logic [7:0] e);
      for (int i = 0; i < 40; i++)
      begin
         net(1'b0, 16'h0066, 16'h0, 1'b0);
         if (rv[sh+:8] === e)
            break;
      end
      chk({8'h0, rv[sh+:8]}, {8'h0, e});
   endtask : poll
   task t_mode;
      @(posedge clk);
      dmode <= 16'h0004;
      net(1'b1, 16'h000a, 16'h0002, 1'b0);
      chk({15'h0, mreq}, 16'h0001);
      chk(mval, 16'h0002);
      net(1'b1, 16'h0106, 16'h0007, 1'b0);
      net(1'b0, 16'h0106, 16'h0, 1'b0);
      chk(rv, 16'h0004);
      @(posedge clk);
      dmode <= 16'h0005;
      net(1'b0, 16'h000a, 16'h0, 1'b0);
      chk(rv, 16'h0002);
      net(1'b0, 16'h0106, 16'h0, 1'b0);
      chk(rv, 16'h0005);
   endtask : t_mode
   task t_read;
      @(posedge clk);
      lat <= 4'h8;
      net(1'b1, 16'h0064, 16'h03ef, 1'b0);
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk(rv, 16'hffff);
      net(1'b0, 16'h0065, 16'h0, 1'b0);
      chk(rv, 16'h0000);
      net(1'b0, 16'h0064, 16'h0, 1'b0);
      chk(rv, 16'h03ef);
      poll(0, 8'h00);
      net(1'b0, 16'h0065, 16'h0, 1'b0);
      chk(rv, 16'h0310);
   endtask : t_read
   task t_write;
      net(1'b1, 16'h0065, 16'h1234, 1'b0);
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk({8'h0, rv[15:8]}, 16'h00ff);
      poll(8, 8'h00);
      chk(wlast, 16'h1234);
      @(posedge clk);
      code <= 8'h03;
      net(1'b1, 16'h0065, 16'h0042, 1'b0);
      poll(8, 8'h03);
      chk(wlast, 16'h0042);
      @(posedge clk);
      code <= 8'h00;
      poll(0, 8'h00);
      repeat (30) @(posedge clk);
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk(rv, 16'h0300);
   endtask : t_write
   task t_disable;
      net(1'b0, 16'h0300, 16'h0, 1'b1);
      net(1'b0, 16'h01fc, 16'h0, 1'b0);
      net(1'b1, 16'h0064, 16'h0000, 1'b0);
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk(rv, 16'h00ff);
      net(1'b1, 16'h0065, 16'h0007, 1'b0);
      net(1'b0, 16'h0065, 16'h0, 1'b0);
      chk(rv, 16'h0000);
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk(rv, 16'h00ff);
   endtask : t_disable
   // A reset in mid-run returns the window to its disabled state.
   task t_reset;
      net(1'b1, 16'h0064, 16'h0123, 1'b0);
      poll(0, 8'h00);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk(rv, 16'h00ff);
      net(1'b0, 16'h0064, 16'h0, 1'b0);
      chk(rv, 16'h0000);
      net(1'b0, 16'h0065, 16'h0, 1'b0);
      chk(rv, 16'h0000);
   endtask : t_reset
   task results;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   initial
   begin
      {rst_n, wr, rd, reg_n, wd, dmode, code, lat} = '0;
      {n_fail, comparisons, cyc} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      net(1'b0, 16'h0066, 16'h0, 1'b0);
      chk(rv, 16'h00ff);
      t_mode();
      t_read();
      @(posedge clk);
      lat <= 4'h1;
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         code <= rd_errs[i];
         poll(0, rd_errs[i]);
      end
      @(posedge clk);
      code <= 8'h00;
      t_write();
      t_disable();
      t_reset();
      results();
   end
endmodule : indirect_parameter_access_regs_tb
`default_nettype wire
